/* File: sfc_flash_decoder.sv */
// Command decoder of a serial NOR flash: constants package and top-level module.
// Assumes the serial pins arrive unsynchronised and the array engine runs on core_clk.
package sfc_pkg;
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_JEDEC_ID     = 8'h9f;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_READ         = 8'h03;
    localparam logic [7:0] OP_FAST_READ    = 8'h0b;
    localparam logic [7:0] OP_PARAM_READ   = 8'h5a;
    localparam logic [7:0] OP_SIGNATURE    = 8'hab;
    localparam logic [7:0] OP_MAKER_PART   = 8'h90;
    localparam logic [7:0] OP_DUAL_FETCH   = 8'h3b;
    localparam logic [7:0] OP_SECTOR_WIPE  = 8'h20;
    localparam logic [7:0] OP_BLOCK_WIPE_A = 8'h52;
    localparam logic [7:0] OP_BLOCK_WIPE_B = 8'hd8;
    localparam logic [7:0] OP_CHIP_WIPE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B  = 8'hc7;
    localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OP_SECUR_READ   = 8'h2b;
    localparam logic [7:0] OP_SECUR_LOCK   = 8'h2f;
    localparam logic [7:0] OP_OTP_ENTER    = 8'hb1;
    localparam logic [7:0] OP_OTP_EXIT     = 8'hc1;
    localparam logic [7:0] OP_DEEP_PD      = 8'hb9;
    // Frame lengths in bytes, opcode included.
    localparam logic [3:0] LEN_ONE   = 4'h1;
    localparam logic [3:0] LEN_TWO   = 4'h2;
    localparam logic [3:0] LEN_ADDR  = 4'h4;
    localparam logic [3:0] LEN_DUMMY = 4'h5;
    localparam logic [3:0] LEN_MAX   = 4'hf;
    // Status register layout; only the mask bits are writable.
    localparam int         SR_BUSY    = 0;
    localparam int         SR_LATCH   = 1;
    localparam logic [7:0] SR_WMASK   = 8'hbc;
    localparam logic [7:0] SR_RESET   = 8'h00;
    localparam int         SEC_CUSTOM = 1;
    // Events handed to the array engine.
    localparam int         EV_KIND_W    = 3;
    localparam int         EV_ADDR_W    = 24;
    localparam int         EV_W         = 35;
    localparam logic [2:0] EV_PROG_DATA = 3'h0;
    localparam logic [2:0] EV_PROG_GO   = 3'h1;
    localparam logic [2:0] EV_SECTOR    = 3'h2;
    localparam logic [2:0] EV_BLOCK     = 3'h3;
    localparam logic [2:0] EV_CHIP      = 3'h4;
    localparam int         EV_DEPTH     = 2;
    typedef enum logic [2:0] {
        SRC_NONE, SRC_ARRAY, SRC_STATUS, SRC_JEDEC, SRC_MAKER, SRC_SIG, SRC_SECUR
    } sfc_src_e;
endpackage

`timescale 1ns/10ps
module sfc_flash_decoder #(
    parameter logic [7:0]  MAKER_ID     = 8'h11,   // Arbitrary value.
    parameter logic [15:0] PART_ID      = 16'h2233, // Arbitrary value.
    parameter logic [7:0]  SIG_ID       = 8'h44,   // Arbitrary value.
    parameter logic        FACTORY_LOCK = 1'b0
) (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic                         sclk,
    input  wire logic                         cs_n,
    input  wire logic                         sio0_in,
    output logic                              sio0_out,
    output logic                              sio0_oe,
    output logic                              so_out,
    output logic                              so_oe,
    input  wire logic                         wp_n,
    input  wire logic                         busy,
    output logic [sfc_pkg::EV_ADDR_W-1:0]     rd_addr,
    output logic                              rd_param,
    input  wire logic [7:0]                   rd_data,
    output logic                              ev_valid,
    input  wire logic                         ev_ready,
    output logic [sfc_pkg::EV_KIND_W-1:0]     ev_kind,
    output logic [sfc_pkg::EV_ADDR_W-1:0]     ev_addr,
    output logic [7:0]                        ev_data,
    output logic [7:0]                        status_bits,
    output logic                              write_latch,
    output logic                              otp_mode,
    output logic                              deep_pd,
    output logic                              sec_lock
);
    import sfc_pkg::*;

    logic       sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3;
    logic       si_s1, si_s2, wp_s1, wp_s2;
    logic       sclk_rise, sclk_fall, cs_rise, active, byte_done, fire, len_ok, hpm;
    logic [2:0] bitcnt, obit;
    logic [3:0] bytecnt, hdr_len, next_hdr;
    logic [6:0] shreg;
    logic [7:0] in_byte, opcode, sr, sr_new, oshift, next_out;
    logic [15:0] addr_hi;
    logic [1:0] out_idx;
    logic       order, dual, next_dual, out_en, out_load, pp_push, in_ready, pend_valid;
    logic [EV_W-1:0] pend_word, ev_word;
    sfc_src_e   src, next_src;

    // Two flops on every pin, three on sclk and cs_n; only the second stage and later are read by logic.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
            {cs_s1, cs_s2, cs_s3} <= 3'h7;
            {si_s1, si_s2, wp_s1, wp_s2} <= 4'h3;
        end else begin
            {sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
            {cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
            {si_s1, si_s2, wp_s1, wp_s2} <= {sio0_in, si_s1, wp_n, wp_s1};
        end
    end

    assign active    = !cs_s2;
    assign sclk_rise = sclk_s2 && !sclk_s3 && active;
    assign sclk_fall = !sclk_s2 && sclk_s3 && active;
    assign cs_rise   = cs_s2 && !cs_s3;
    assign in_byte   = {shreg, si_s2};
    assign byte_done = sclk_rise && (bitcnt == 3'h7);
    assign hpm       = sr[7] && !wp_s2;

    // Input shifter and bit and byte counters; the counters are cleared whenever the chip is deselected.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitcnt <= 3'h0;
            bytecnt <= 4'h0;
            shreg <= 7'h00;
        end else if (!active) begin
            bitcnt <= 3'h0;
            bytecnt <= 4'h0;
        end else if (sclk_rise) begin
            shreg <= in_byte[6:0];
            bitcnt <= bitcnt + 3'h1;
            if (byte_done && bytecnt != LEN_MAX) begin
                bytecnt <= bytecnt + 4'h1;
            end
        end
    end

    // Opcode decode; while asleep only the signature read gets an answer.
    always_comb begin
        next_src = SRC_NONE;
        next_hdr = LEN_ONE;
        next_dual = 1'b0;
        case (in_byte)
            OP_READ:        begin next_src = SRC_ARRAY;  next_hdr = LEN_ADDR;  end
            OP_FAST_READ,
            OP_PARAM_READ:  begin next_src = SRC_ARRAY;  next_hdr = LEN_DUMMY; end
            OP_DUAL_FETCH:  begin
                next_src = SRC_ARRAY;
                next_hdr = LEN_DUMMY;
                next_dual = 1'b1;
            end
            OP_STATUS_READ: next_src = SRC_STATUS;
            OP_JEDEC_ID:    next_src = SRC_JEDEC;
            OP_SECUR_READ:  next_src = SRC_SECUR;
            OP_MAKER_PART:  begin next_src = SRC_MAKER;  next_hdr = LEN_ADDR;  end
            OP_SIGNATURE:   begin next_src = SRC_SIG;    next_hdr = LEN_ADDR;  end
            default:        next_src = SRC_NONE;
        endcase
        if (deep_pd && in_byte != OP_SIGNATURE) begin
            next_src = SRC_NONE;
        end
    end

    // Frame role: opcode, output source and the point where output starts.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            opcode <= 8'h00;
            src <= SRC_NONE;
            hdr_len <= LEN_ONE;
            dual <= 1'b0;
            rd_param <= 1'b0;
            out_en <= 1'b0;
            order <= 1'b0;
            sr_new <= SR_RESET;
        end else if (!active) begin
            out_en <= 1'b0;
        end else if (byte_done) begin
            if (bytecnt == 4'h0) begin
                opcode <= in_byte;
                src <= next_src;
                hdr_len <= next_hdr;
                dual <= next_dual;
                rd_param <= (in_byte == OP_PARAM_READ);
                out_en <= (next_src != SRC_NONE) && (next_hdr == LEN_ONE);
            end else begin
                if (src != SRC_NONE && bytecnt + 4'h1 == hdr_len) begin
                    out_en <= 1'b1;
                end
                if (bytecnt == 4'h1) begin
                    sr_new <= in_byte;
                end
                if (bytecnt == 4'h3) begin
                    order <= in_byte[0];
                end
            end
        end
    end

    // Address collection, most significant byte first, then advance per byte moved.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_hi <= 16'h0000;
            rd_addr <= 24'h000000;
        end else if (byte_done && (bytecnt == 4'h1 || bytecnt == 4'h2)) begin
            addr_hi <= {addr_hi[7:0], in_byte};
        end else if (byte_done && bytecnt == 4'h3) begin
            rd_addr <= {addr_hi, in_byte};
        end else if (out_load && src == SRC_ARRAY) begin
            rd_addr <= rd_addr + 24'h000001;
        end else if (pp_push) begin
            rd_addr[7:0] <= rd_addr[7:0] + 8'h01; // Stays within the page.
        end
    end

    // Byte to send next, chosen by the source latched at the opcode.
    always_comb begin
        next_out = 8'h00;
        unique case (src)
            SRC_NONE:   next_out = 8'h00;
            SRC_ARRAY:  next_out = rd_data;
            SRC_STATUS: next_out = status_bits;
            SRC_JEDEC:  next_out = (out_idx == 2'h0) ? MAKER_ID :
                                   (out_idx == 2'h1) ? PART_ID[15:8] : PART_ID[7:0];
            SRC_MAKER:  next_out = (out_idx[0] ^ order) ? PART_ID[7:0] : MAKER_ID;
            SRC_SIG:    next_out = SIG_ID;
            SRC_SECUR:  next_out = {6'h00, sec_lock, FACTORY_LOCK};
        endcase
    end

    assign out_load = sclk_fall && out_en && (obit == 3'h0);

    // Output shifter: one bit per falling edge, two in dual mode.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            obit <= 3'h0;
            out_idx <= 2'h0;
            oshift <= 8'h00;
            so_out <= 1'b0;
            sio0_out <= 1'b0;
        end else if (!active) begin
            obit <= 3'h0;
            out_idx <= 2'h0;
        end else if (sclk_fall && out_en) begin
            if (obit == 3'h0) begin
                out_idx <= (src == SRC_JEDEC && out_idx == 2'h2) ? 2'h0 : out_idx + 2'h1;
            end
            if (dual) begin
                {sio0_out, so_out} <= out_load ? next_out[7:6] : oshift[7:6];
                oshift <= out_load ? {next_out[5:0], 2'h0} : {oshift[5:0], 2'h0};
                obit <= obit + 3'h2;
            end else begin
                so_out <= out_load ? next_out[7] : oshift[7];
                oshift <= out_load ? {next_out[6:0], 1'b0} : {oshift[6:0], 1'b0};
                obit <= obit + 3'h1;
            end
        end
    end

    assign so_oe   = out_en;
    assign sio0_oe = out_en && dual;

    // A write-class frame counts only with the exact length, or at least five bytes for page write, ended on a byte boundary.
    always_comb begin
        case (opcode)
            OP_STATUS_WRITE:                 len_ok = (bytecnt == LEN_TWO);
            OP_SECTOR_WIPE, OP_BLOCK_WIPE_A,
            OP_BLOCK_WIPE_B:                 len_ok = (bytecnt == LEN_ADDR);
            OP_PAGE_WRITE:                   len_ok = (bytecnt >= LEN_DUMMY);
            OP_SIGNATURE:                    len_ok = (bytecnt >= LEN_ONE);
            default:                         len_ok = (bytecnt == LEN_ONE);
        endcase
    end
    assign fire = cs_rise && (bitcnt == 3'h0) && len_ok
                  && (!deep_pd || opcode == OP_SIGNATURE);

    // Mode flags, write latch and status; a content change consumes the latch.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_latch <= 1'b0;
            sr <= SR_RESET;
            sec_lock <= 1'b0;
            otp_mode <= 1'b0;
            deep_pd <= 1'b0;
        end else if (fire) begin
            case (opcode)
                OP_WRITE_UNLOCK: write_latch <= 1'b1;
                OP_WRITE_LOCK:   write_latch <= 1'b0;
                OP_STATUS_WRITE: if (write_latch && !busy) begin
                    write_latch <= 1'b0;
                    if (!hpm) begin
                        sr <= (sr & ~SR_WMASK) | (sr_new & SR_WMASK);
                    end
                end
                OP_SECTOR_WIPE, OP_BLOCK_WIPE_A, OP_BLOCK_WIPE_B, OP_CHIP_WIPE_A,
                OP_CHIP_WIPE_B, OP_PAGE_WRITE: if (write_latch && !busy) begin
                    write_latch <= 1'b0;
                end
                OP_SECUR_LOCK:   sec_lock <= 1'b1;
                OP_OTP_ENTER:    otp_mode <= 1'b1;
                OP_OTP_EXIT:     otp_mode <= 1'b0;
                OP_DEEP_PD:      deep_pd <= 1'b1;
                OP_SIGNATURE:    deep_pd <= 1'b0;
                default:         deep_pd <= deep_pd;
            endcase
        end
    end

    // Status image registered once per cycle for readout and the port.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_bits <= SR_RESET;
        end else begin
            status_bits <= {sr[7], 1'b0, sr[5:2], write_latch, busy};
        end
    end

    assign pp_push = byte_done && opcode == OP_PAGE_WRITE && bytecnt >= LEN_ADDR
                     && write_latch && !busy && !deep_pd;

    // One staging word ahead of the buffer; a new event overwrites it whether or not it has drained.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_valid <= 1'b0;
            pend_word <= '0;
        end else begin
            if (pend_valid && in_ready) begin
                pend_valid <= 1'b0;
            end
            if (pp_push) begin
                pend_valid <= 1'b1;
                pend_word <= {EV_PROG_DATA, rd_addr, in_byte};
            end else if (fire && write_latch && !busy) begin
                case (opcode)
                    OP_PAGE_WRITE: begin
                        pend_valid <= 1'b1;
                        pend_word <= {EV_PROG_GO, rd_addr, 8'h00};
                    end
                    OP_SECTOR_WIPE: begin
                        pend_valid <= 1'b1;
                        pend_word <= {EV_SECTOR, rd_addr, 8'h00};
                    end
                    OP_BLOCK_WIPE_A, OP_BLOCK_WIPE_B: begin
                        pend_valid <= 1'b1;
                        pend_word <= {EV_BLOCK, rd_addr, 8'h00};
                    end
                    OP_CHIP_WIPE_A, OP_CHIP_WIPE_B: begin
                        pend_valid <= 1'b1;
                        pend_word <= {EV_CHIP, 24'h000000, 8'h00};
                    end
                    default: pend_valid <= pend_valid && !in_ready;
                endcase
            end
        end
    end

    sfc_pair_buffer #(.WIDTH(EV_W), .DEPTH(EV_DEPTH)) u_ev_buf (
        .clk       (core_clk),
        .rst_n     (rst_n),
        .in_valid  (pend_valid),
        .in_ready  (in_ready),
        .in_data   (pend_word),
        .out_valid (ev_valid),
        .out_ready (ev_ready),
        .out_data  (ev_word)
    );
    assign {ev_kind, ev_addr, ev_data} = ev_word;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    unlock_sets_a: assert property (fire && opcode == OP_WRITE_UNLOCK |=> write_latch)
        else $error("write latch not set by unlock");
    lock_clears_a: assert property (fire && opcode == OP_WRITE_LOCK |=> !write_latch)
        else $error("write latch not cleared by lock");
    status_load_a: assert property (fire && opcode == OP_STATUS_WRITE && write_latch && !busy
        && !hpm |=> ((sr ^ $past(sr_new)) & SR_WMASK) == 8'h00)
        else $error("status bits not loaded");
    maker_order_a: assert property (out_load && src == SRC_MAKER && out_idx == 2'h0
        |=> so_out == (order ? PART_ID[7] : MAKER_ID[7]))
        else $error("identity order wrong");
    lock_sticky_a: assert property (sec_lock |=> sec_lock)
        else $error("customer lock bit cleared");
    otp_enter_a: assert property (fire && opcode == OP_OTP_ENTER |=> otp_mode)
        else $error("secured area mode not entered");
    otp_exit_a: assert property (fire && opcode == OP_OTP_EXIT |=> !otp_mode)
        else $error("secured area mode not left");
    sleep_wake_a: assert property (deep_pd && cs_rise && opcode != OP_SIGNATURE
        |=> deep_pd)
        else $error("sleep left by wrong command");
    sector_event_a: assert property (fire && opcode == OP_SECTOR_WIPE && write_latch
        && !busy |=> pend_valid && pend_word[EV_W-1 -: EV_KIND_W] == EV_SECTOR)
        else $error("sector event missing");
    shift_fall_a: assert property ($changed(so_out) |-> $past(sclk_fall))
        else $error("output moved off a falling edge");
endmodule

/* File: sfc_pair_buffer.sv */
// Small valid/ready buffer for events from the decoder to the array engine.
// Assumes both sides run on one clock; data leave from storage flops.
`timescale 1ns/10ps
module sfc_pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, rd_ptr;
    logic [AW:0]      count;
    logic             push, pop;

    // Full and empty come straight from the count, so a stalled drain back-pressures.
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth; count tracks occupancy.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

/* File: sfc_host_model.sv */
// Host model for the serial pins of the flash command decoder.
// Assumes serial mode 0 with the clock resting low and an 80 ns clock period.
`timescale 1ns/10ps
module sfc_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      sio0_in,
    input  wire logic so_out,
    input  wire logic so_oe,
    input  wire logic sio0_out,
    input  wire logic sio0_oe
);
    // Bits seen on the second data line, read by the bench after a dual read.
    logic [31:0] rx_hi;
    // The clock rests low and the select rests high between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sio0_in = 1'b1;
    end

    // One frame: nb bits out MSB first, then nr bytes in. The data line is inverted when
    // the frame ends, so a decoder that samples outside the frame sees no stale value.
    task automatic xfer(input logic [63:0] tx, input int nb, input int nr,
                        output logic [31:0] rx);
        int i;
        rx = '0;
        rx_hi = '0;
        cs_n = 1'b0;
        for (i = 0; i < nb + 8 * nr; i++) begin
            sio0_in = (i < nb) ? tx[nb - 1 - i] : ~sio0_in;
            // A released line reads as the inverse of its last value, so a missing enable shows.
            #40 rx = {rx[30:0], so_oe ? so_out : ~so_out};
            rx_hi = {rx_hi[30:0], sio0_oe ? sio0_out : ~sio0_out};
            sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #20 cs_n = 1'b1;
        sio0_in = ~sio0_in;
        #40;
    endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the flash command decoder, driven through the host model.
// Assumes the engine side answers from rd_addr at once and the events are popped here.
`timescale 1ns/10ps
module tb_top;
    import sfc_pkg::*;
    localparam logic [7:0]  MAKER = 8'h2d;   // Arbitrary value.
    localparam logic [15:0] PART  = 16'h7e81; // Arbitrary value.
    localparam logic [7:0]  SIG   = 8'hc3;   // Arbitrary value.
    logic        core_clk, rst_n, sclk, cs_n, sio0_in, wp_n, busy, ev_ready;
    logic        sio0_out, sio0_oe, so_out, so_oe, rd_param, ev_valid;
    logic        write_latch, otp_mode, deep_pd, sec_lock;
    logic [23:0] rd_addr, ev_addr;
    logic [7:0]  rd_data, ev_data, status_bits;
    logic [2:0]  ev_kind;
    logic [31:0] rx;
    int          fails, compares;

    sfc_flash_decoder #(.MAKER_ID(MAKER), .PART_ID(PART), .SIG_ID(SIG), .FACTORY_LOCK(1'b0))
        dut_u (.core_clk, .rst_n, .sclk, .cs_n,
        .sio0_in, .sio0_out, .sio0_oe, .so_out, .so_oe, .wp_n, .busy, .rd_addr,
        .rd_param, .rd_data, .ev_valid, .ev_ready, .ev_kind, .ev_addr, .ev_data,
        .status_bits, .write_latch, .otp_mode, .deep_pd, .sec_lock);
    sfc_host_model host_u (.sclk, .cs_n, .sio0_in, .so_out, .so_oe, .sio0_out, .sio0_oe);

    // Array contents are a simple function of the address, so any byte can be predicted.
    assign rd_data = rd_addr[7:0] ^ 8'h5a;

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic cmd(input logic [63:0] tx, input int nb, input int nr);
        host_u.xfer(tx, nb, nr, rx);
    endtask

    task automatic t_latch;
        cmd(8'h06, 8, 0);
        chk(write_latch, 1, "latch not set");
        cmd(8'h05, 8, 1);
        chk(rx[7:0], 8'h02, "status read");
        cmd(8'h04, 8, 0);
        chk(write_latch, 0, "latch not cleared");
        // The unlock opcode followed by one stray bit.
        cmd(9'h00c, 9, 0);
        chk(write_latch, 0, "ragged frame accepted");
        cmd(16'h013c, 16, 0);
        chk(status_bits, 8'h00, "status load without latch");
        cmd(8'h06, 8, 0);
        cmd(16'h013c, 16, 0);
        chk(status_bits, 8'h3c, "status load");
        $display("test latch done");
    endtask

    task automatic t_ident;
        cmd(32'h90000000, 32, 2);
        chk(rx[15:8], MAKER, "maker first");
        chk(rx[7:0], PART[7:0], "part second");
        cmd(32'h90000001, 32, 2);
        chk(rx[15:8], PART[7:0], "part first");
        chk(rx[7:0], MAKER, "maker second");
        cmd(8'h9f, 8, 3);
        chk(rx[23:0], {MAKER, PART}, "jedec id");
        $display("test ident done");
    endtask

    task automatic t_modes;
        cmd(8'h2f, 8, 0);
        chk(sec_lock, 1, "lock bit");
        cmd(8'h2b, 8, 1);
        chk(rx[7:0], 8'h02, "security read");
        cmd(8'hb1, 8, 0);
        chk(otp_mode, 1, "otp entry");
        cmd(8'hc1, 8, 0);
        chk(otp_mode, 0, "otp exit");
        chk(sec_lock, 1, "lock bit changed");
        cmd(8'hb9, 8, 0);
        chk(deep_pd, 1, "sleep");
        cmd(8'h06, 8, 0);
        chk(write_latch, 0, "command taken asleep");
        cmd(8'hab, 8, 0);
        chk(deep_pd, 0, "wake");
        cmd(32'hab000000, 32, 1);
        chk(rx[7:0], SIG, "signature");
        $display("test modes done");
    endtask

    // The engine stalls while three erases queue up; an unlatched erase must add nothing.
    task automatic t_erase;
        logic [2:0]  k[3];
        logic [23:0] a[3];
        k = '{EV_SECTOR, EV_BLOCK, EV_CHIP};
        a = '{24'h123456, 24'habcdef, 24'h0};
        cmd(8'h06, 8, 0);
        cmd(32'h20123456, 32, 0);
        cmd(8'h06, 8, 0);
        cmd(32'h52abcdef, 32, 0);
        cmd(8'h06, 8, 0);
        cmd(8'hc7, 8, 0);
        cmd(32'h20000000, 32, 0);
        for (int i = 0; i < 3; i++) begin
            chk(ev_valid, 1, "event missing");
            chk(ev_kind, k[i], "event kind");
            if (i < 2)
                chk(ev_addr, a[i], "event address");
            @(posedge core_clk) #1 ev_ready = 1'b1;
            @(posedge core_clk) #1 ev_ready = 1'b0;
        end
        chk(ev_valid, 0, "unlatched erase queued");
        $display("test erase done");
    endtask

    // One programmed byte gives a data event, then a go event once the frame ends.
    task automatic t_program;
        cmd(8'h06, 8, 0);
        cmd(40'h02000100a5, 40, 0);
        chk(write_latch, 0, "latch kept by program");
        for (int i = 0; i < 2; i++) begin
            chk(ev_valid, 1, "program event missing");
            chk(ev_kind, i ? EV_PROG_GO : EV_PROG_DATA, "program event kind");
            if (i == 0)
                chk({ev_addr, ev_data}, 32'h000100a5, "program data word");
            @(posedge core_clk) #1 ev_ready = 1'b1;
            @(posedge core_clk) #1 ev_ready = 1'b0;
        end
        chk(ev_valid, 0, "extra program event");
        $display("test program done");
    endtask

    task automatic t_read;
        cmd(32'h03000010, 32, 2);
        chk(rx[15:0], {8'h10 ^ 8'h5a, 8'h11 ^ 8'h5a}, "plain read");
        cmd(40'h5a00004000, 40, 1);
        chk(rx[7:0], 8'h40 ^ 8'h5a, "param read");
        chk(rd_param, 1, "param space");
        cmd(40'h0b00002000, 40, 1);
        chk(rx[7:0], 8'h20 ^ 8'h5a, "fast read");
        chk(rd_param, 0, "array space");
        // Dual: bytes 6a and 6b, odd bits on the input pin, even bits on the output pin.
        cmd(40'h3b00003000, 40, 1);
        chk({host_u.rx_hi[7:0], rx[7:0]}, 16'h7789, "dual read");
        $display("test read done");
    endtask

    task automatic complete_run;
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Reset for two cycles, then let the pin synchronisers fill before the first frame.
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        busy = 1'b0;
        ev_ready = 1'b0;
        fails = 0;
        compares = 0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge core_clk);
        t_latch();
        t_ident();
        t_modes();
        t_erase();
        t_program();
        t_read();
        complete_run();
    end

    // The tests need well under 100 us; a hang is cut off well after that.
    initial begin
        #400000;
        fails++;
        complete_run();
    end
endmodule
